// file: src/async_serial_pkg.sv
// Shared constants and types for the asynchronous serial transmitter/receiver.
// Assumes a single 200 MHz clock domain and an AHB-Lite register bus with
// one word per register index (byte address = index * 4).
package async_serial_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
	localparam logic [7:0] IDX_PERIPH_FLAGS      = 8'h0C;
	localparam logic [7:0] IDX_RECEIVE_STATUS    = 8'h18;
	localparam logic [7:0] IDX_TRANSMIT_BUFFER   = 8'h19;
	localparam logic [7:0] IDX_RECEIVE_BUFFER    = 8'h1A;
	localparam logic [7:0] IDX_PERIPH_ENABLE     = 8'h8C;
	localparam logic [7:0] IDX_TRANSMIT_STATUS   = 8'h98;
	localparam logic [7:0] IDX_BAUD_DIVISOR      = 8'h99;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int TXS_NINTH_BIT   = 0;
	localparam int TXS_SHIFT_EMPTY = 1;
	localparam int TXS_HIGH_SPEED  = 2;
	localparam int TXS_SYNC        = 4;
	localparam int TXS_ENABLE      = 5;
	localparam int TXS_NINE_SEL    = 6;
	localparam int RCS_NINTH_BIT   = 0;
	localparam int RCS_OVERRUN     = 1;
	localparam int RCS_FRAMING     = 2;
	localparam int RCS_CONT_RX     = 4;
	localparam int RCS_NINE_SEL    = 6;
	localparam int RCS_PORT_EN     = 7;
	localparam int FLG_TX_EMPTY    = 4;
	localparam int FLG_RX_AVAIL    = 5;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and writable masks
	localparam logic [7:0] TXS_RESET   = 8'h02;
	localparam logic [7:0] REG8_RESET  = 8'h00;
	localparam logic [7:0] TXS_WR_MASK = 8'hF5;
	localparam logic [7:0] RCS_WR_MASK = 8'hF0;

	////////////////////////////////////////////////////////////////////////////
	// Timing counts: sixteen samples per bit, divide by four for the slow mode
	localparam logic [3:0] OS_LAST      = 4'hF;
	localparam logic [3:0] OS_MID       = 4'h7;
	localparam logic [1:0] SLOW_PRE_LAST = 2'h3;
	localparam logic [3:0] BITS_EIGHT   = 4'h8;
	localparam logic [3:0] BITS_NINE    = 4'h9;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_START = 2'b01,
		TX_DATA  = 2'b10,
		TX_STOP  = 2'b11
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_t;

	typedef struct packed {
		logic       framing;
		logic       ninth;
		logic [7:0] data;
	} rx_entry_t;

endpackage

// file: src/async_serial_tx_rx.sv
// Asynchronous serial transmitter and receiver with AHB-Lite register access.
// Assumes one 200 MHz clock, synchronous active-high reset, and a remote
// asynchronous serial port on the pins; the receive pin is asynchronous.
//
// What this block does
// - Shift register reloads from the buffer only after the stop bit, then at once.
// - Buffer-to-shifter move takes one cycle, then buffer-empty flag bit 4 sets.
// - Buffer-empty flag ignores its enable, software cannot clear it; buffer write clears.
// - Read-only shifter-empty status, transmit control bit 1, no interrupt.
// - Setting transmit enable sets buffer-empty flag; loading buffer clears it.
// - Transmit enable is bit 5; shifting needs buffered data and a baud tick.
// - Buffer written before enable still transmits; empty shifter frees buffer at once.
// - Clearing transmit enable aborts, resets transmitter, releases the pin.
// - With nine-bit select bit 6, bit 0 is sent as ninth bit at transfer.
// - Receive recovery oversamples at sixteen times the bit rate.
// - Reception enabled by continuous-receive bit 4 in async mode.
// - After stop bit, move received byte to FIFO if room; set data-available bit 5.
// - Data-available flag is read-only, clears when FIFO read empty; enable gates request.
// - Receive buffer is a two-entry FIFO; a third byte may shift in meanwhile.
// - FIFO full at next stop bit sets overrun bit 1 and drops the byte.
// - Overrun blocks all FIFO writes; cleared only by toggling receive enable.
// - Framing error bit 2 sets when the stop bit samples as zero.
// - Framing error and ninth bit travel with their byte through the FIFO.
// - Frame is start, eight or nine data bits LSB first, one stop; no parity.
// - Baud generator runs at sixteen or sixty-four times bit rate, select bit 2.
// - Asynchronous operation when synchronous select bit 4 is clear.
// - Transmitter and receiver independent, sharing mode and baud setting; each has its own nine-bit select.
//
// The AHB-Lite slave port was left to the implementer.
module async_serial_tx_rx #(
	parameter int RX_FIFO_DEPTH = 2
) (
	// Clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	// AHB-Lite slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hwdata_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// Serial pins
	input  wire logic        serial_in_pin_in,
	output logic             serial_out_pin_out,
	output logic             serial_out_pin_oe_out,
	// Gated peripheral request
	output logic             periph_request_out
);
	import async_serial_pkg::*;

	localparam int PTR_W = (RX_FIFO_DEPTH > 1) ? $clog2(RX_FIFO_DEPTH) : 1;
	localparam logic [PTR_W:0]   FIFO_FULL_CNT = (PTR_W + 1)'(RX_FIFO_DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST      = PTR_W'(RX_FIFO_DEPTH - 1);

	////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0]      intctl_q, pie_q, txs_q, rcs_q, divisor_q, txbuf_q;
	logic            txbuf_full_q, transmit_buffer_empty_flag_q;
	tx_state_t       tx_state_q;
	logic [8:0]      tx_sh_q;
	logic [3:0]      tx_cnt_q, tx_bits_q;
	logic            tx_line_q, tx_oe_q;
	logic [7:0]      brg_cnt_q;
	logic            brg_tick_q;
	logic [1:0]      pre_q;
	logic            sync1_q, sync2_q, sync3_q, rx_lvl_q, rx_prev_q;
	rx_state_t       rx_state_q;
	logic [3:0]      rx_cnt_q, rx_bits_q;
	logic [8:0]      rx_sh_q;
	rx_entry_t       fifo_mem [RX_FIFO_DEPTH];
	logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
	logic [PTR_W:0]  fifo_cnt_q;
	logic            pend_q, pend_wr_q, pend_ok_q;
	logic [7:0]      pend_idx_q;
	logic [31:0]     hrdata_q;
	logic            hreadyout_q, req_q;

	////////////////////////////////////////////////////////////////////////////
	// Decode of control fields
	wire tx_en      = txs_q[TXS_ENABLE];
	wire tx_nine    = txs_q[TXS_NINE_SEL];
	wire high_speed = txs_q[TXS_HIGH_SPEED];
	wire async_mode = !txs_q[TXS_SYNC];
	wire port_en    = rcs_q[RCS_PORT_EN];
	wire rx_nine    = rcs_q[RCS_NINE_SEL];
	wire rx_en      = rcs_q[RCS_CONT_RX] && async_mode && port_en;
	wire overrun    = rcs_q[RCS_OVERRUN];

	////////////////////////////////////////////////////////////////////////////
	// Bus decode: a transfer is accepted in its address phase, acted on in the
	// next cycle with one wait state, so a read right after a write sees it
	wire        accept   = hsel_in && (htrans_in == HTRANS_NONSEQ) && hready_in && hreadyout_q;
	wire        in_range = (haddr_in[31:10] == 22'h0);
	wire        wr_go    = pend_q && pend_wr_q && pend_ok_q;
	wire        rd_go    = pend_q && !pend_wr_q && pend_ok_q;
	wire        wr_txs   = wr_go && (pend_idx_q == IDX_TRANSMIT_STATUS);
	wire        wr_rcs   = wr_go && (pend_idx_q == IDX_RECEIVE_STATUS);
	wire        wr_txbuf = wr_go && (pend_idx_q == IDX_TRANSMIT_BUFFER);
	wire [7:0]  wdata    = hwdata_in[7:0];
	wire [7:0]  txs_new  = (txs_q & ~TXS_WR_MASK) | (wdata & TXS_WR_MASK);
	wire [7:0]  rcs_new  = (rcs_q & ~RCS_WR_MASK) | (wdata & RCS_WR_MASK);
	wire        tx_en_rise = wr_txs && !tx_en && txs_new[TXS_ENABLE];

	////////////////////////////////////////////////////////////////////////////
	// Baud generator: tick every divisor+1 clocks, prescale by four in slow mode
	wire brg_run     = (tx_en || rx_en) && port_en;
	wire sample_tick = brg_tick_q && (high_speed || (pre_q == SLOW_PRE_LAST));

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in || !brg_run)
		begin
			brg_cnt_q  <= 8'h00;
			brg_tick_q <= 1'b0;
			pre_q      <= 2'h0;
		end
		else
		begin
			brg_tick_q <= (brg_cnt_q == divisor_q);
			brg_cnt_q  <= (brg_cnt_q == divisor_q) ? 8'h00 : brg_cnt_q + 8'h01;
			if (brg_tick_q)
				pre_q <= pre_q + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmitter: buffer, shifter and framing
	wire       tx_load    = tx_en && port_en && txbuf_full_q && (tx_state_q == TX_IDLE);
	wire       tx_bit_end = sample_tick && (tx_cnt_q == OS_LAST);
	wire [3:0] tx_nbits   = tx_nine ? BITS_NINE : BITS_EIGHT;
	wire       tx_empty   = (tx_state_q == TX_IDLE);

	// Buffer and its empty flag; a write that lands with a load refills it
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			txbuf_q      <= REG8_RESET;
			txbuf_full_q <= 1'b0;
			transmit_buffer_empty_flag_q       <= 1'b0;
		end
		else
		begin
			if (wr_txbuf)
				txbuf_q <= wdata;
			txbuf_full_q <= wr_txbuf || (txbuf_full_q && !tx_load);
			if (wr_txbuf)
				transmit_buffer_empty_flag_q <= 1'b0;
			else if (tx_load || tx_en_rise)
				transmit_buffer_empty_flag_q <= 1'b1;
		end
	end

	// Shifter; clearing the enable drops any character in flight
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in || !tx_en || !port_en)
		begin
			tx_state_q <= TX_IDLE;
			tx_sh_q    <= 9'h1FF;
			tx_cnt_q   <= 4'h0;
			tx_bits_q  <= 4'h0;
		end
		else
		begin
			if (tx_state_q != TX_IDLE && sample_tick)
				tx_cnt_q <= tx_cnt_q + 4'h1;
			case (tx_state_q)
				TX_IDLE:
				begin
					if (tx_load)
					begin
						tx_sh_q    <= {tx_nine ? txs_q[TXS_NINTH_BIT] : 1'b1, txbuf_q};
						tx_state_q <= TX_START;
						tx_cnt_q   <= 4'h0;
						tx_bits_q  <= 4'h0;
					end
				end
				TX_START:
					if (tx_bit_end)
						tx_state_q <= TX_DATA;
				TX_DATA:
					if (tx_bit_end)
					begin
						tx_sh_q   <= {1'b1, tx_sh_q[8:1]};
						tx_bits_q <= tx_bits_q + 4'h1;
						if (tx_bits_q == tx_nbits - 4'h1)
							tx_state_q <= TX_STOP;
					end
				TX_STOP:
					if (tx_bit_end)
						tx_state_q <= TX_IDLE;
				default:
					tx_state_q <= TX_IDLE;
			endcase
		end
	end

	// Pin drive: low start bit, data LSB first, high stop and idle
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			tx_line_q <= 1'b1;
			tx_oe_q   <= 1'b0;
		end
		else
		begin
			tx_oe_q   <= tx_en && port_en && async_mode;
			tx_line_q <= (tx_state_q == TX_START) ? 1'b0 :
			             (tx_state_q == TX_DATA)  ? tx_sh_q[0] : 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive pin synchroniser; a level counts once the second and third agree
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			sync1_q   <= 1'b1;
			sync2_q   <= 1'b1;
			sync3_q   <= 1'b1;
			rx_lvl_q  <= 1'b1;
			rx_prev_q <= 1'b1;
		end
		else
		begin
			sync1_q   <= serial_in_pin_in;
			sync2_q   <= sync1_q;
			sync3_q   <= sync2_q;
			if (sync2_q == sync3_q)
				rx_lvl_q <= sync3_q;
			rx_prev_q <= rx_lvl_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receiver: start search, centre sampling, stop check
	wire       rx_fall    = rx_prev_q && !rx_lvl_q;
	wire [3:0] rx_nbits   = rx_nine ? BITS_NINE : BITS_EIGHT;
	wire       rx_done    = (rx_state_q == RX_STOP) && sample_tick && (rx_cnt_q == OS_LAST);
	wire       fifo_full  = (fifo_cnt_q == FIFO_FULL_CNT);
	wire       fifo_push  = rx_done && !fifo_full && !overrun;
	wire       set_ovr    = rx_done && fifo_full && !overrun;
	wire       pop_rd     = rd_go && (pend_idx_q == IDX_RECEIVE_BUFFER);
	wire       fifo_pop   = pop_rd && (fifo_cnt_q != '0);
	wire [8:0] rx_word    = rx_nine ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
	wire       receive_data_available_flag       = (fifo_cnt_q != '0);
	rx_entry_t head;
	assign head = fifo_mem[rd_ptr_q];

	// Runs from its own enable only, so transmit activity never disturbs it
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in || !rx_en)
		begin
			rx_state_q <= RX_IDLE;
			rx_cnt_q   <= 4'h0;
			rx_bits_q  <= 4'h0;
			rx_sh_q    <= 9'h000;
		end
		else
		begin
			if (rx_state_q != RX_IDLE && sample_tick)
				rx_cnt_q <= rx_cnt_q + 4'h1;
			case (rx_state_q)
				RX_IDLE:
					if (rx_fall)
					begin
						rx_state_q <= RX_START;
						rx_cnt_q   <= 4'h0;
						rx_bits_q  <= 4'h0;
					end
				RX_START:
					if (sample_tick && rx_cnt_q == OS_MID)
					begin
						rx_cnt_q   <= 4'h0;                      // Restart so samples land mid-bit
						rx_state_q <= rx_lvl_q ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (sample_tick && rx_cnt_q == OS_LAST)
					begin
						rx_sh_q   <= {rx_lvl_q, rx_sh_q[8:1]};
						rx_bits_q <= rx_bits_q + 4'h1;
						if (rx_bits_q == rx_nbits - 4'h1)
							rx_state_q <= RX_STOP;
					end
				RX_STOP:
					if (rx_done)
						rx_state_q <= RX_IDLE;
				default:
					rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// Two-entry FIFO carries status with each byte; contents survive an enable toggle
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			wr_ptr_q   <= '0;
			rd_ptr_q   <= '0;
			fifo_cnt_q <= '0;
		end
		else
		begin
			if (fifo_push)
			begin
				fifo_mem[wr_ptr_q] <= '{framing: !rx_lvl_q, ninth: rx_word[8], data: rx_word[7:0]};
				wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
			end
			if (fifo_pop)
				rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
			if (fifo_push && !fifo_pop)
				fifo_cnt_q <= fifo_cnt_q + 1'b1;
			else if (fifo_pop && !fifo_push)
				fifo_cnt_q <= fifo_cnt_q - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read mux
	function automatic logic [7:0] read_mux(input logic [7:0] idx);
		case (idx)
			IDX_INTERRUPT_CONTROL: read_mux = intctl_q;
			IDX_PERIPH_FLAGS:      read_mux = {2'b00, receive_data_available_flag, transmit_buffer_empty_flag_q, 4'h0};
			IDX_RECEIVE_STATUS:    read_mux = {rcs_q[7:3], head.framing, overrun, head.ninth};
			IDX_TRANSMIT_BUFFER:   read_mux = txbuf_q;
			IDX_RECEIVE_BUFFER:    read_mux = head.data;
			IDX_PERIPH_ENABLE:     read_mux = pie_q;
			IDX_TRANSMIT_STATUS:   read_mux = {txs_q[7:2], tx_empty, txs_q[0]};
			IDX_BAUD_DIVISOR:      read_mux = divisor_q;
			default:               read_mux = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus slave: phase tracking, read data and one wait state per transfer
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			pend_q      <= 1'b0;
			pend_wr_q   <= 1'b0;
			pend_ok_q   <= 1'b0;
			pend_idx_q  <= 8'h00;
			hrdata_q    <= 32'h0000_0000;
			hreadyout_q <= 1'b1;
		end
		else
		begin
			pend_q      <= accept;
			hreadyout_q <= !accept;
			if (accept)
			begin
				pend_wr_q  <= hwrite_in;
				pend_ok_q  <= in_range;
				pend_idx_q <= haddr_in[9:2];
			end
			if (pend_q)
				hrdata_q <= rd_go ? {24'h00_0000, read_mux(pend_idx_q)} : 32'h0000_0000;
		end
	end

	// Software-written registers; the overrun bit is hardware-set only
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			intctl_q  <= REG8_RESET;
			pie_q     <= REG8_RESET;
			txs_q     <= TXS_RESET;
			rcs_q     <= REG8_RESET;
			divisor_q <= REG8_RESET;
		end
		else
		begin
			if (wr_go && pend_idx_q == IDX_INTERRUPT_CONTROL)
				intctl_q <= wdata;
			if (wr_go && pend_idx_q == IDX_PERIPH_ENABLE)
				pie_q <= wdata;
			if (wr_go && pend_idx_q == IDX_BAUD_DIVISOR)
				divisor_q <= wdata;
			if (wr_txs)
				txs_q <= txs_new;
			if (wr_rcs)
				rcs_q[7:4] <= rcs_new[7:4];
			if (!rx_en)
				rcs_q[RCS_OVERRUN] <= 1'b0;
			else if (set_ovr)
				rcs_q[RCS_OVERRUN] <= 1'b1;
		end
	end

	// Combined request: each flag gated by its own enable bit
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
			req_q <= 1'b0;
		else
			req_q <= (transmit_buffer_empty_flag_q && pie_q[FLG_TX_EMPTY]) || (receive_data_available_flag && pie_q[FLG_RX_AVAIL]);
	end

	assign hrdata_out            = hrdata_q;
	assign hreadyout_out         = hreadyout_q;
	assign hresp_out             = 1'b0;
	assign serial_out_pin_out    = tx_line_q;
	assign serial_out_pin_oe_out = tx_oe_q;
	assign periph_request_out    = req_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_tx_released;
		(tx_state_q == TX_IDLE) ##1 !serial_out_pin_oe_out;
	endsequence

	a_tx_no_reload: assert property ((tx_state_q == TX_STOP) && tx_en && port_en && !tx_bit_end
		|=> (tx_state_q == TX_STOP))
		else $error("shifter reloaded mid character");
	a_tx_load_flag: assert property (tx_load && !wr_txbuf |=> transmit_buffer_empty_flag_q && tx_state_q == TX_START)
		else $error("load did not set empty flag");
	a_tx_write_clr: assert property (wr_txbuf |=> !transmit_buffer_empty_flag_q && txbuf_full_q)
		else $error("buffer write did not clear flag");
	a_tx_enable_flag: assert property (tx_en_rise && !wr_txbuf |=> transmit_buffer_empty_flag_q)
		else $error("enable did not set empty flag");
	a_tx_abort_pin: assert property ($fell(tx_en) |=> s_tx_released)
		else $error("transmitter not released on disable");
	a_tx_start_low: assert property ($rose(tx_state_q == TX_START) |=> !serial_out_pin_out)
		else $error("start bit not low");
	a_rx_ovr_block: assert property (overrun |=> (fifo_cnt_q <= $past(fifo_cnt_q)))
		else $error("FIFO written during overrun");
	a_rx_push_avail: assert property (fifo_push |=> receive_data_available_flag && fifo_cnt_q != '0)
		else $error("push did not raise data available");
	a_rx_fifo_bound: assert property (fifo_full && rx_done && rx_en && !fifo_pop
		|=> overrun && fifo_full)
		else $error("overrun not flagged on full FIFO");

endmodule

// file: bench/remote_serial_port.sv
// Behavioural far-end serial port: decodes frames on the device's transmit
// line and sends frames onto its receive line. Assumes 80 ns per bit.
module remote_serial_port #(
	parameter int BIT_NS = 80
) (
	// Lines seen from the far end
	input  wire logic tx_line_in,
	input  wire logic nine_in,
	output logic      rx_line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] got_q [$];
	logic [8:0] w;
	int         bit_ns; // The bench retunes this when it slows the link down
	initial
	begin
		rx_line_out = 1'b1;
		bit_ns = BIT_NS;
	end

	////////////////////////////////////////////////////////////////////////
	// Centre sampling; a frame without a high stop is dropped
	always
	begin
		@(negedge tx_line_in);
		#(bit_ns / 2);
		if (tx_line_in === 1'b0)
		begin
			w = 9'h000;
			for (int i = 0; i < (nine_in ? 9 : 8); i++)
			begin
				#(bit_ns);
				w[i] = tx_line_in;
			end
			#(bit_ns);
			if (tx_line_in === 1'b1)
				got_q.push_back(w);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// One frame, LSB first, then an idle bit so the next start edge is seen;
	// edges sit 1 ns past the clock so they never race the sampling flop
	task automatic send(input logic [8:0] d, input logic nine, input logic stop);
		#1;
		rx_line_out = 1'b0;
		#(bit_ns);
		for (int i = 0; i < (nine ? 9 : 8); i++)
		begin
			rx_line_out = d[i];
			#(bit_ns);
		end
		rx_line_out = stop;
		#(bit_ns);
		rx_line_out = 1'b1;
		#(bit_ns);
	endtask
endmodule

// file: bench/async_serial_tx_rx_tb_top.sv
// Self-checking bench for the serial transmitter/receiver.
// Assumes divisor 0 with high speed set: 16 clocks of 5 ns per bit.
module async_serial_tx_rx_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import async_serial_pkg::*;
	logic        clk, rst, hsel, hwrite, nine, rxl, txo, oe, req, hready, hresp;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	int          n_fail, compares;
	wire         tx_wire = oe ? txo : 1'b1; // Pull-up on the released line

	async_serial_tx_rx i_async_serial_tx_rx (.ref_clk_in(clk), .rst_in(rst),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .serial_in_pin_in(rxl),
		.serial_out_pin_out(txo), .serial_out_pin_oe_out(oe), .periph_request_out(req));
	remote_serial_port i_remote_serial_port (.tx_line_in(tx_wire), .nine_in(nine),
		.rx_line_out(rxl));

	always #2.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	// Bus master, checks and closing
	task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {22'h000000, i, 2'b00};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata[7:0];
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] q;
		bus(i, 1'b1, d, q);
	endtask
	task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rdc(input string nm, input logic [7:0] i, input logic [7:0] m,
		input logic [7:0] exp);
		logic [7:0] q;
		bus(i, 1'b0, 8'h00, q);
		check(nm, {1'b0, q & m}, {1'b0, exp});
	endtask
	task automatic wait_got(input int n);
		for (int k = 0; k < 4000 && i_remote_serial_port.got_q.size() < n; k++)
			@(posedge clk);
		if (i_remote_serial_port.got_q.size() < n)
			check("frames", 9'(i_remote_serial_port.got_q.size()), 9'(n));
	endtask
	task automatic final_report();
		$display("Counts: %0d compares, %0d fails", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		rdc("txs", IDX_TRANSMIT_STATUS, 8'hFF, TXS_RESET);
		rdc("flags", IDX_PERIPH_FLAGS, 8'hFF, 8'h00);
		rdc("baud", IDX_BAUD_DIVISOR, 8'hFF, 8'h00);
		rdc("unmapped", 8'h40, 8'hFF, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_tx();
		wr(IDX_BAUD_DIVISOR, 8'h00);
		wr(IDX_RECEIVE_STATUS, 8'h80);
		wr(IDX_TRANSMIT_STATUS, 8'h24);
		rdc("flag on enable", IDX_PERIPH_FLAGS, 8'hFF, 8'h10);
		rdc("shift empty", IDX_TRANSMIT_STATUS, 8'hFF, 8'h26);
		wr(IDX_TRANSMIT_BUFFER, 8'h5A);
		wr(IDX_TRANSMIT_BUFFER, 8'hC3);
		rdc("flag queued", IDX_PERIPH_FLAGS, 8'hFF, 8'h00);
		wait_got(2);
		check("tx byte 0", i_remote_serial_port.got_q[0], 9'h05A);
		check("tx byte 1", i_remote_serial_port.got_q[1], 9'h0C3);
		rdc("flag drained", IDX_PERIPH_FLAGS, 8'hFF, 8'h10);
		i_remote_serial_port.got_q.delete();
		$display("test tx done");
	endtask
	task automatic t_nine_req();
		nine <= 1'b1;
		wr(IDX_TRANSMIT_STATUS, 8'h45);
		wr(IDX_TRANSMIT_BUFFER, 8'h81);
		wr(IDX_PERIPH_ENABLE, 8'h10);
		wr(IDX_TRANSMIT_STATUS, 8'h65);
		wait_got(1);
		check("ninth bit", i_remote_serial_port.got_q[0], 9'h181);
		wr(IDX_PERIPH_FLAGS, 8'h00);
		rdc("flag sticky", IDX_PERIPH_FLAGS, 8'hFF, 8'h10);
		check("request on", {8'h00, req}, 9'h001);
		wr(IDX_PERIPH_ENABLE, 8'h00);
		@(posedge clk); // Request flop follows the enable one cycle later
		check("request off", {8'h00, req}, 9'h000);
		nine <= 1'b0;
		i_remote_serial_port.got_q.delete();
		$display("test nine done");
	endtask
	task automatic t_abort();
		wr(IDX_TRANSMIT_STATUS, 8'h24);
		wr(IDX_TRANSMIT_BUFFER, 8'hFF);
		repeat (60) @(posedge clk);
		wr(IDX_TRANSMIT_STATUS, 8'h04);
		repeat (3) @(posedge clk);
		check("pin released", {8'h00, oe}, 9'h000);
		rdc("shifter reset", IDX_TRANSMIT_STATUS, 8'hFF, 8'h06);
		repeat (300) @(posedge clk);
		i_remote_serial_port.got_q.delete();
		$display("test abort done");
	endtask
	task automatic t_rx();
		wr(IDX_RECEIVE_STATUS, 8'hD0);
		i_remote_serial_port.send(9'h1A5, 1'b1, 1'b1);
		i_remote_serial_port.send(9'h03C, 1'b1, 1'b0);
		i_remote_serial_port.send(9'h07E, 1'b1, 1'b1);
		rdc("rcs head", IDX_RECEIVE_STATUS, 8'hFF, 8'hD3);
		rdc("rx avail", IDX_PERIPH_FLAGS, 8'h20, 8'h20);
		rdc("rx 0", IDX_RECEIVE_BUFFER, 8'hFF, 8'hA5);
		rdc("rcs next", IDX_RECEIVE_STATUS, 8'hFF, 8'hD6);
		rdc("rx 1", IDX_RECEIVE_BUFFER, 8'hFF, 8'h3C);
		rdc("rx empty", IDX_PERIPH_FLAGS, 8'h20, 8'h00);
		i_remote_serial_port.send(9'h05A, 1'b1, 1'b1);
		rdc("inhibited", IDX_PERIPH_FLAGS, 8'h20, 8'h00);
		wr(IDX_RECEIVE_STATUS, 8'h80);
		wr(IDX_RECEIVE_STATUS, 8'hD0);
		rdc("overrun clr", IDX_RECEIVE_STATUS, 8'h02, 8'h00);
		i_remote_serial_port.send(9'h066, 1'b1, 1'b1);
		rdc("rx resumed", IDX_RECEIVE_BUFFER, 8'hFF, 8'h66);
		$display("test rx done");
	endtask
	task automatic t_slow();
		// Sixty-four clocks per bit, first from the slow prescaler, then from the divisor
		i_remote_serial_port.bit_ns = 320;
		wr(IDX_TRANSMIT_STATUS, 8'h20);
		wr(IDX_TRANSMIT_BUFFER, 8'h96);
		wait_got(1);
		check("slow tx", i_remote_serial_port.got_q[0], 9'h096);
		i_remote_serial_port.got_q.delete();
		wr(IDX_TRANSMIT_STATUS, 8'h04);
		wr(IDX_BAUD_DIVISOR, 8'h03);
		wr(IDX_RECEIVE_STATUS, 8'h90);
		i_remote_serial_port.send(9'h0E1, 1'b0, 1'b1);
		rdc("divided rx", IDX_RECEIVE_BUFFER, 8'hFF, 8'hE1);
		$display("test slow done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog; the whole run needs about 20 us
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h00000000;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		nine = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_tx();
		t_nine_req();
		t_abort();
		t_rx();
		t_slow();
		final_report();
	end
	initial
	begin
		#200us;
		n_fail++;
		final_report();
	end
endmodule
